//--- rtl/gp_timer.sv
// two 16-bit counters, joinable into a 32-bit timer or real-time clock
//
// Overview of operation
// - reset: inactive, counters and loads all ones
// - reset: prescale counters and registers zero
// - config 0 timer32, config 1 clock32
// - config 4 splits into two 16-bit counters
// - 32-bit load write fills both halves
// - 32-bit value read joins both halves
// - joined timer uses first mode field only
// - joined timer counts down, reloads after zero
// - zero sets sticky timeout flag, masked interrupt
// - trigger pulse one cycle at zero
// - load write while running reloads next cycle
// - stall enable plus stall input freezes counter
// - clock counts up, first entry loads one
// - pin clock divided to one hertz tick
// - clock match rolls count to zero
// - clock match sets flag, clear bit clears
// - stall-ignore bit keeps clock counting
// - split counters have 8-bit prescaler each
// - split counter reloads after zero, one-shot stops
// - prescale N gives N+1 clocks per step
// - 32-bit modes use only the even pin
`timescale 1ns/1ps
module gp_timer
  import gpt_pkg::*;
#(
  parameter int RTC_DIVIDE = RTC_DIV
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // system stall request, same clock
  input wire logic stall_in,
  // even capture/compare pin, clock source in clock mode
  input wire logic ccp_even_in,
  // triggers and interrupt
  output logic trig_a_out,
  output logic trig_b_out,
  output logic irq_out
);
  localparam int DIV_W = $clog2(RTC_DIVIDE);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] cfg;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic en_a;
  logic en_b;
  logic stl_a;
  logic stl_b;
  logic ote_a;
  logic ote_b;
  logic rtc_ign;
  logic [15:0] ilr_a;
  logic [15:0] ilr_b;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic [31:0] match;
  logic [7:0] pr_a;
  logic [7:0] pr_b;
  logic [7:0] pre_a;
  logic [7:0] pre_b;
  logic ris_to_a;
  logic ris_to_b;
  logic ris_rtc;
  logic im_to_a;
  logic im_to_b;
  logic im_rtc;
  logic rtc_seen;
  logic [DIV_W-1:0] div_cnt;
  logic ccp_s;
  logic ccp_d;
  logic [31:0] rd_word;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire wr_cfg = wr_in && (addr_in == OFF_CFG);
  wire wr_mode_a = wr_in && (addr_in == OFF_MODE_A);
  wire wr_mode_b = wr_in && (addr_in == OFF_MODE_B);
  wire wr_ctl = wr_in && (addr_in == OFF_CTL);
  wire wr_imr = wr_in && (addr_in == OFF_IMR);
  wire wr_icr = wr_in && (addr_in == OFF_ICR);
  wire wr_ilr_a = wr_in && (addr_in == OFF_ILR_A);
  wire wr_ilr_b = wr_in && (addr_in == OFF_ILR_B);
  wire wr_match = wr_in && (addr_in == OFF_MATCH_A);
  wire wr_pr_a = wr_in && (addr_in == OFF_PR_A);
  wire wr_pr_b = wr_in && (addr_in == OFF_PR_B);

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire mode32 = (cfg == CFG_32_TIMER);
  wire mode_rtc = (cfg == CFG_32_RTC);
  wire split = (cfg == CFG_16_SPLIT);
  wire wide = mode32 || mode_rtc;
  wire a_ok = (mode_a == MODE_ONESHOT) || (mode_a == MODE_PERIODIC);
  wire b_ok = (mode_b == MODE_ONESHOT) || (mode_b == MODE_PERIODIC);
  wire frz_a = stl_a && stall_in;
  wire frz_b = stl_b && stall_in;
  // the clock keeps running through a stall when told to
  wire rtc_frz = (stl_a || stl_b) && stall_in && !rtc_ign;
  wire [31:0] cnt32 = {cnt_b, cnt_a};

  // ---------------------------------------------------------------
  // run conditions; a cleared enable simply stops stepping
  // ---------------------------------------------------------------
  wire run32 = mode32 && en_a && a_ok && !frz_a;
  wire run_a16 = split && en_a && a_ok && !frz_a;
  wire run_b16 = split && en_b && b_ok && !frz_b;
  wire rtc_run = mode_rtc && en_a && !rtc_frz;

  // ---------------------------------------------------------------
  // joined timer events
  // ---------------------------------------------------------------
  wire zero32 = run32 && (cnt32 == 32'h00000000);
  wire hit32 = run32 && (cnt32 == 32'h00000001);

  // ---------------------------------------------------------------
  // split counter events; a step happens when the prescaler is out
  // ---------------------------------------------------------------
  // the zero count lasts a full prescaled step like every other count
  wire zero_a = run_a16 && (cnt_a == 16'h0000) && (pre_a == 8'h00);
  wire dec_a = run_a16 && !zero_a && (pre_a == 8'h00);
  wire hit_a = dec_a && (cnt_a == 16'h0001);
  wire zero_b = run_b16 && (cnt_b == 16'h0000) && (pre_b == 8'h00);
  wire dec_b = run_b16 && !zero_b && (pre_b == 8'h00);
  wire hit_b = dec_b && (cnt_b == 16'h0001);

  // ---------------------------------------------------------------
  // clock mode: even pin edges divided down to one tick per second
  // ---------------------------------------------------------------
  wire ccp_rise = ccp_s && !ccp_d;
  wire div_last = (div_cnt == DIV_W'(RTC_DIVIDE - 1));
  wire rtc_tick = rtc_run && ccp_rise && div_last;
  wire rtc_hit = rtc_tick && (cnt32 == match);
  wire rtc_entry = wr_cfg && (wdata_in[2:0] == CFG_32_RTC) && !rtc_seen;

  // ---------------------------------------------------------------
  // flag sources and one-shot enable clears
  // ---------------------------------------------------------------
  wire set_to_a = hit32 || hit_a;
  wire set_to_b = hit_b;
  wire clr_en_a = (zero32 || zero_a) && (mode_a == MODE_ONESHOT);
  wire clr_en_b = zero_b && (mode_b == MODE_ONESHOT);
  wire [31:0] ris_word = (32'(ris_to_a) << INT_TO_A) | (32'(ris_rtc) << INT_RTC)
                       | (32'(ris_to_b) << INT_TO_B);
  wire [31:0] imr_word = (32'(im_to_a) << INT_TO_A) | (32'(im_rtc) << INT_RTC)
                       | (32'(im_to_b) << INT_TO_B);
  wire [31:0] mis_word = ris_word & imr_word;

  // pin passes two flops before anything looks at it
  sync2 #(
    .W(1)
  ) u_ccp_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .d_in(ccp_even_in),
    .q_out(ccp_s)
  );

  // ---------------------------------------------------------------
  // next counter values
  // ---------------------------------------------------------------
  logic [15:0] next_cnt_a;
  logic [15:0] next_cnt_b;
  logic [7:0] next_pre_a;
  logic [7:0] next_pre_b;

  // software loads take priority so a new value lands next cycle
  always_comb begin
    next_cnt_a = cnt_a;
    next_cnt_b = cnt_b;
    next_pre_a = pre_a;
    next_pre_b = pre_b;
    if (wide) begin
      if (wr_ilr_a) begin
        {next_cnt_b, next_cnt_a} = wdata_in;
      end else if (zero32) begin
        {next_cnt_b, next_cnt_a} = {ilr_b, ilr_a};
      end else if (run32) begin
        {next_cnt_b, next_cnt_a} = cnt32 - 32'h00000001;
      end else if (rtc_hit) begin
        {next_cnt_b, next_cnt_a} = 32'h00000000;
      end else if (rtc_tick) begin
        {next_cnt_b, next_cnt_a} = cnt32 + 32'h00000001;
      end
    end else begin
      if (wr_ilr_a) begin
        next_cnt_a = wdata_in[15:0];
        next_pre_a = pr_a;
      end else if (zero_a) begin
        next_cnt_a = ilr_a;
        next_pre_a = pr_a;
      end else if (dec_a) begin
        next_cnt_a = cnt_a - 16'h0001;
        next_pre_a = pr_a;
      end else if (run_a16) begin
        next_pre_a = pre_a - 8'h01;
      end
      if (wr_ilr_b) begin
        next_cnt_b = wdata_in[15:0];
        next_pre_b = pr_b;
      end else if (zero_b) begin
        next_cnt_b = ilr_b;
        next_pre_b = pr_b;
      end else if (dec_b) begin
        next_cnt_b = cnt_b - 16'h0001;
        next_pre_b = pr_b;
      end else if (run_b16) begin
        next_pre_b = pre_b - 8'h01;
      end
    end
    // first entry to clock mode starts the count at one
    if (rtc_entry) begin
      {next_cnt_b, next_cnt_a} = RTC_START;
    end
  end

  // ---------------------------------------------------------------
  // counters and prescalers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_a <= CNT_RST;
      cnt_b <= CNT_RST;
      pre_a <= PRE_RST;
      pre_b <= PRE_RST;
    end else if (ce_in) begin
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
      pre_a <= next_pre_a;
      pre_b <= next_pre_b;
    end
  end

  // ---------------------------------------------------------------
  // configuration, mode and load registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg <= CFG_RST;
      mode_a <= 2'h0;
      mode_b <= 2'h0;
      ilr_a <= CNT_RST;
      ilr_b <= CNT_RST;
      pr_a <= PRE_RST;
      pr_b <= PRE_RST;
      match <= MATCH_RST;
      rtc_seen <= 1'b0;
    end else if (ce_in) begin
      if (wr_cfg) cfg <= wdata_in[2:0];
      if (rtc_entry) rtc_seen <= 1'b1;
      if (wr_mode_a) mode_a <= wdata_in[1:0];
      if (wr_mode_b) mode_b <= wdata_in[1:0]; // ignored while joined
      if (wr_ilr_a) begin
        ilr_a <= wdata_in[15:0];
        if (wide) ilr_b <= wdata_in[31:16];
      end else if (wr_ilr_b) begin
        ilr_b <= wdata_in[15:0];
      end
      if (wr_pr_a) pr_a <= wdata_in[7:0];
      if (wr_pr_b) pr_b <= wdata_in[7:0];
      if (wr_match) match <= wide ? wdata_in : {16'h0000, wdata_in[15:0]};
    end
  end

  // ---------------------------------------------------------------
  // control register; one-shot completion clears the enable
  // ---------------------------------------------------------------
  // a software write in the same cycle as a one-shot finish wins,
  // so a restart issued right at the end is not swallowed
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_a <= 1'b0;
      en_b <= 1'b0;
      stl_a <= 1'b0;
      stl_b <= 1'b0;
      ote_a <= 1'b0;
      ote_b <= 1'b0;
      rtc_ign <= 1'b0;
    end else if (ce_in) begin
      if (wr_ctl) begin
        en_a <= wdata_in[CTL_EN_A];
        en_b <= wdata_in[CTL_EN_B];
        stl_a <= wdata_in[CTL_STALL_A];
        stl_b <= wdata_in[CTL_STALL_B];
        ote_a <= wdata_in[CTL_OTE_A];
        ote_b <= wdata_in[CTL_OTE_B];
        rtc_ign <= wdata_in[CTL_RTC_IGN];
      end else begin
        if (clr_en_a) en_a <= 1'b0;
        if (clr_en_b) en_b <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky status, mask; a new event beats a same-cycle clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ris_to_a <= 1'b0;
      ris_to_b <= 1'b0;
      ris_rtc <= 1'b0;
      im_to_a <= 1'b0;
      im_to_b <= 1'b0;
      im_rtc <= 1'b0;
    end else if (ce_in) begin
      ris_to_a <= set_to_a || (ris_to_a && !(wr_icr && wdata_in[INT_TO_A]));
      ris_to_b <= set_to_b || (ris_to_b && !(wr_icr && wdata_in[INT_TO_B]));
      ris_rtc <= rtc_hit || (ris_rtc && !(wr_icr && wdata_in[INT_RTC]));
      if (wr_imr) begin
        im_to_a <= wdata_in[INT_TO_A];
        im_to_b <= wdata_in[INT_TO_B];
        im_rtc <= wdata_in[INT_RTC];
      end
    end
  end

  // ---------------------------------------------------------------
  // output triggers: one-cycle pulse as the counter steps from one to zero
  // ---------------------------------------------------------------
  // second trigger only exists while split; joined modes use the
  // even side alone
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_a_out <= 1'b0;
      trig_b_out <= 1'b0;
    end else if (ce_in) begin
      trig_a_out <= ote_a && set_to_a && !wr_ilr_a;
      trig_b_out <= ote_b && set_to_b && !wr_ilr_b;
    end
  end

  // ---------------------------------------------------------------
  // clock-mode divider on synchronised pin edges
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ccp_d <= 1'b0;
      div_cnt <= '0;
    end else if (ce_in) begin
      ccp_d <= ccp_s;
      if (!rtc_run) begin
        div_cnt <= div_cnt; // hold phase while stopped or frozen
      end else if (ccp_rise) begin
        div_cnt <= div_last ? '0 : div_cnt + DIV_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux; unmapped addresses read as zero
  // ---------------------------------------------------------------
  always_comb begin
    case (addr_in)
      OFF_CFG: rd_word = {29'h0, cfg};
      OFF_MODE_A: rd_word = {30'h0, mode_a};
      OFF_MODE_B: rd_word = {30'h0, mode_b};
      OFF_CTL: rd_word = (32'(en_a) << CTL_EN_A) | (32'(stl_a) << CTL_STALL_A)
                        | (32'(rtc_ign) << CTL_RTC_IGN) | (32'(ote_a) << CTL_OTE_A)
                        | (32'(en_b) << CTL_EN_B) | (32'(stl_b) << CTL_STALL_B)
                        | (32'(ote_b) << CTL_OTE_B);
      OFF_IMR: rd_word = imr_word;
      OFF_RIS: rd_word = ris_word;
      OFF_MIS: rd_word = mis_word;
      OFF_ILR_A: rd_word = wide ? {ilr_b, ilr_a} : {16'h0, ilr_a};
      OFF_ILR_B: rd_word = {16'h0, ilr_b};
      OFF_MATCH_A: rd_word = match;
      OFF_PR_A: rd_word = {24'h0, pr_a};
      OFF_PR_B: rd_word = {24'h0, pr_b};
      OFF_VAL_A: rd_word = wide ? cnt32 : {16'h0, cnt_a};
      OFF_VAL_B: rd_word = {16'h0, cnt_b};
      default: rd_word = 32'h0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 32'h0;
    end else if (ce_in) begin
      rdata_out <= rd_in ? rd_word : 32'h0;
    end
  end

  // single interrupt line from the masked status
  assign irq_out = |mis_word;
endmodule

//--- rtl/gpt_pkg.sv
// constants shared by the two-counter general-purpose timer
package gpt_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_MODE_A = 8'h04;
  localparam logic [7:0] OFF_MODE_B = 8'h08;
  localparam logic [7:0] OFF_CTL = 8'h0C;
  localparam logic [7:0] OFF_IMR = 8'h18;
  localparam logic [7:0] OFF_RIS = 8'h1C;
  localparam logic [7:0] OFF_MIS = 8'h20;
  localparam logic [7:0] OFF_ICR = 8'h24;
  localparam logic [7:0] OFF_ILR_A = 8'h28;
  localparam logic [7:0] OFF_ILR_B = 8'h2C;
  localparam logic [7:0] OFF_MATCH_A = 8'h30;
  localparam logic [7:0] OFF_PR_A = 8'h38;
  localparam logic [7:0] OFF_PR_B = 8'h3C;
  localparam logic [7:0] OFF_VAL_A = 8'h48;
  localparam logic [7:0] OFF_VAL_B = 8'h4C;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_EN_A = 0;
  localparam int CTL_STALL_A = 1;
  localparam int CTL_RTC_IGN = 4;
  localparam int CTL_OTE_A = 5;
  localparam int CTL_EN_B = 8;
  localparam int CTL_STALL_B = 9;
  localparam int CTL_OTE_B = 13;
  // ---------------------------------------------------------------
  // interrupt status / mask / clear fields
  // ---------------------------------------------------------------
  localparam int INT_TO_A = 0;
  localparam int INT_RTC = 3;
  localparam int INT_TO_B = 8;
  // ---------------------------------------------------------------
  // configuration and mode encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_32_RTC = 3'h1;
  localparam logic [2:0] CFG_16_SPLIT = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [15:0] CNT_RST = 16'hFFFF;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [31:0] MATCH_RST = 32'hFFFFFFFF;
  localparam logic [31:0] RTC_START = 32'h00000001;
  localparam int RTC_SRC_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int RTC_DIV = RTC_SRC_HZ / RTC_TICK_HZ;
endpackage

//--- rtl/sync2.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // ---------------------------------------------------------------
  // two stages; only the second stage is read outside
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

//--- sim/gp_timer_checker.sv
// port-level assertions for the two-counter timer
`timescale 1ns/1ps
module gp_timer_checker
  import gpt_pkg::*;
#(
  parameter int RTC_DIVIDE = RTC_DIV
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // stall, pin, outputs
  input wire logic stall_in,
  input wire logic ccp_even_in,
  input wire logic trig_a_out,
  input wire logic trig_b_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----
  // software settings shadow
  // ----
  logic [2:0] cfg_sh;
  logic stall_a_sh;
  logic ote_a_sh;
  logic take_wr;
  assign take_wr = wr_in && ce_in;
  // hardware never alters these bits, so a write shadow is exact
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_sh <= CFG_RST;
      stall_a_sh <= 1'b0;
      ote_a_sh <= 1'b0;
    end else if (take_wr && addr_in == OFF_CFG) begin
      cfg_sh <= wdata_in[2:0];
    end else if (take_wr && addr_in == OFF_CTL) begin
      stall_a_sh <= wdata_in[CTL_STALL_A];
      ote_a_sh <= wdata_in[CTL_OTE_A];
    end
  end
  // ----
  // properties
  // ----
  property p_trig_a_pulse;
    trig_a_out |=> !trig_a_out;
  endproperty
  a_trig_a_pulse: assert property (p_trig_a_pulse) else $error("first trigger too long");
  property p_trig_b_pulse;
    trig_b_out |=> !trig_b_out;
  endproperty
  a_trig_b_pulse: assert property (p_trig_b_pulse) else $error("second trigger too long");
  property p_trig_a_enabled;
    trig_a_out |-> $past(ote_a_sh);
  endproperty
  a_trig_a_enabled: assert property (p_trig_a_enabled) else $error("trigger not enabled");
  property p_stall_freeze;
    stall_in && stall_a_sh && cfg_sh != CFG_32_RTC |=> !trig_a_out;
  endproperty
  a_stall_freeze: assert property (p_stall_freeze) else $error("trigger while frozen");
  property p_no_trig_rtc;
    cfg_sh == CFG_32_RTC && $past(cfg_sh) == CFG_32_RTC |-> !trig_a_out;
  endproperty
  a_no_trig_rtc: assert property (p_no_trig_rtc) else $error("trigger in clock mode");
  property p_b_split_only;
    cfg_sh != CFG_16_SPLIT && $past(cfg_sh) != CFG_16_SPLIT |-> !trig_b_out;
  endproperty
  a_b_split_only: assert property (p_b_split_only) else $error("second trigger joined");
  property p_rd_idle;
    !rd_in && ce_in |=> rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_reset_quiet;
    $rose(arst_n_in) |-> rdata_out == 32'h0 && !irq_out && !trig_a_out && !trig_b_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_mask_off;
    take_wr && addr_in == OFF_IMR && wdata_in == 32'h0 |=> !irq_out;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt while masked");
  c_trig_a: cover property (trig_a_out);
  c_trig_b: cover property (trig_b_out);
  c_irq: cover property ($rose(irq_out));
endmodule
bind gp_timer gp_timer_checker #(.RTC_DIVIDE(RTC_DIVIDE)) i_gp_timer_checker (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .stall_in(stall_in), .ccp_even_in(ccp_even_in), .trig_a_out(trig_a_out),
  .trig_b_out(trig_b_out), .irq_out(irq_out));

//--- sim/tb.sv
// self-checking bench for the two-counter timer
`timescale 1ns/1ps
module tb;
  import gpt_pkg::*;
  // ----
  // signals
  // ----
  typedef struct {logic [7:0] addr; logic [31:0] exp;} row_t;
  row_t rows [8] = '{'{OFF_CFG, 32'h0}, '{OFF_CTL, 32'h0}, '{OFF_ILR_A, 32'hFFFFFFFF},
    '{OFF_VAL_A, 32'hFFFFFFFF}, '{OFF_PR_A, 32'h0}, '{OFF_PR_B, 32'h0},
    '{OFF_RIS, 32'h0}, '{8'h44, 32'h0}};
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic stall_in = 1'b0;
  logic ccp_even_in = 1'b0;
  logic pin_run = 1'b0;
  logic [31:0] rdata_out;
  logic trig_a_out;
  logic trig_b_out;
  logic irq_out;
  logic [31:0] v1;
  logic [31:0] v2;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  always #2 clk_in = ~clk_in;
  // pin clock unrelated in phase to the system clock
  // changes on odd nanoseconds so it never lands on a clock edge
  always #10 if (pin_run) ccp_even_in <= #1 ~ccp_even_in;
  // short divider keeps clock-mode ticks at 4 rising pin edges
  gp_timer #(.RTC_DIVIDE(4)) i_gp_timer (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .stall_in(stall_in), .ccp_even_in(ccp_even_in),
    .trig_a_out(trig_a_out), .trig_b_out(trig_b_out), .irq_out(irq_out));
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // cycles until the chosen trigger, bounded so a dead counter cannot hang
  task automatic wait_trig(input bit b, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_in);
      #1 cnt++;
    end while ((b ? trig_b_out : trig_a_out) !== 1'b1 && cnt < 200);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].addr, v1);
      check(v1, rows[i].exp);
    end
    wr(OFF_ILR_A, 32'h00050003);
    rd(OFF_ILR_B, v1);
    check(32'(v1[15:0]), 32'h5);
    rd(OFF_VAL_A, v1);
    check(v1, 32'h00050003);
    // joined one-shot, second mode field says periodic and must be ignored
    wr(OFF_ILR_A, 32'h3);
    wr(OFF_MODE_B, 32'h2);
    wr(OFF_MODE_A, 32'h1);
    wr(OFF_IMR, 32'h1);
    wr(OFF_CTL, 32'h21);
    wait_trig(0, n);
    check(32'(n < 20), 32'h1);
    check(32'(irq_out), 32'h1);
    repeat (10) @(posedge clk_in);
    rd(OFF_CTL, v1);
    check(v1, 32'h20);
    rd(OFF_VAL_A, v1);
    check(v1, 32'h3);
    rd(OFF_MIS, v1);
    check(v1, 32'h1);
    wr(OFF_ICR, 32'h1);
    #1 check(32'(irq_out), 32'h0);
    // periodic spacing, then a load write while running
    wr(OFF_MODE_A, 32'h2);
    wr(OFF_CTL, 32'h21);
    wait_trig(0, n);
    wait_trig(0, n);
    check(n, 32'h4);
    wr(OFF_ILR_A, 32'h6);
    wait_trig(0, n);
    wait_trig(0, n);
    check(n, 32'h7);
    // clock enable low for five edges stretches the next period by five
    @(posedge clk_in);
    ce_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    ce_in <= 1'b1;
    wait_trig(0, n);
    check(n, 32'h6);
    @(posedge clk_in);
    stall_in <= 1'b1;
    wr(OFF_CTL, 32'h23);
    rd(OFF_VAL_A, v1);
    repeat (20) @(posedge clk_in);
    rd(OFF_VAL_A, v2);
    check(v2, v1);
    wr(OFF_CTL, 32'h21);
    wait_trig(0, n);
    check(32'(n <= 8), 32'h1);
    @(posedge clk_in);
    stall_in <= 1'b0;
    wr(OFF_CTL, 32'h0);
    rd(OFF_VAL_A, v1);
    repeat (10) @(posedge clk_in);
    rd(OFF_VAL_A, v2);
    check(v2, v1);
    // pending timeouts show on the line until the mask goes to zero
    check(32'(irq_out), 32'h1);
    wr(OFF_IMR, 32'h0);
    #1 check(32'(irq_out), 32'h0);
    // split halves: periodic prescaled first, one-shot second
    wr(OFF_CFG, 32'h4);
    wr(OFF_MODE_B, 32'h1);
    wr(OFF_PR_A, 32'h2);
    wr(OFF_ILR_A, 32'h3);
    wr(OFF_ILR_B, 32'h2);
    wr(OFF_CTL, 32'h2121);
    wait_trig(1, n);
    check(32'(n < 40), 32'h1);
    wait_trig(0, n);
    wait_trig(0, n);
    check(n, 32'hC);
    rd(OFF_CTL, v1);
    check(v1, 32'h2021);
    rd(OFF_VAL_B, v1);
    check(32'(v1[15:0]), 32'h2);
    // clock mode: first entry loads one, match rolls to zero
    wr(OFF_CTL, 32'h0);
    wr(OFF_CFG, 32'h1);
    rd(OFF_VAL_A, v1);
    check(v1, 32'h1);
    wr(OFF_MATCH_A, 32'h3);
    wr(OFF_IMR, 32'h8);
    wr(OFF_CTL, 32'h1);
    pin_run = 1'b1;
    n = 0;
    while (irq_out !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      #1 n++;
    end
    check(32'(irq_out), 32'h1);
    rd(OFF_VAL_A, v1);
    check(v1, 32'h0);
    wr(OFF_ICR, 32'h8);
    #1 check(32'(irq_out), 32'h0);
    @(posedge clk_in);
    stall_in <= 1'b1;
    wr(OFF_CTL, 32'h13);
    rd(OFF_VAL_A, v1);
    repeat (30) @(posedge clk_in);
    rd(OFF_VAL_A, v2);
    check(32'(v1 !== v2), 32'h1);
    // without the ignore bit the same stall freezes the clock
    wr(OFF_CTL, 32'h3);
    rd(OFF_VAL_A, v1);
    repeat (30) @(posedge clk_in);
    rd(OFF_VAL_A, v2);
    check(v2, v1);
    stall_in <= 1'b0;
    pin_run = 1'b0;
    // reset in mid-run returns the registers to their start values
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(OFF_CTL, v1);
    check(v1, 32'h0);
    rd(OFF_VAL_A, v1);
    check(v1, 32'hFFFFFFFF);
    final_report();
  end
endmodule
